// >>> cxb_pkg.sv
// Shared constants, types and decode functions of the six-by-two crossbar switch
package cxb_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int NUM_M = 6;
  localparam int NUM_S = 2;
  localparam int AW    = 32;
  localparam int DW    = 32;

  typedef logic [2:0]                cxb_port_type;
  typedef logic [3:0]                cxb_id_type;
  typedef logic [1:0]                cxb_trans_type;
  typedef logic [1:0]                cxb_slave_type;
  typedef logic [NUM_M-1:0][AW-1:0]  cxb_maddr_type;
  typedef logic [NUM_M-1:0][DW-1:0]  cxb_mdata_type;
  typedef logic [NUM_M-1:0][2:0]     cxb_msize_type;
  typedef logic [NUM_S-1:0][AW-1:0]  cxb_saddr_type;
  typedef logic [NUM_S-1:0][DW-1:0]  cxb_sdata_type;
  typedef logic [NUM_S-1:0][2:0]     cxb_ssize_type;
  typedef logic [NUM_S-1:0][1:0]     cxb_strans_type;
  typedef logic [NUM_S-1:0][3:0]     cxb_sid_type;

  // ==========================================================================
  // Transfer types and slave indices
  // ==========================================================================
  localparam cxb_trans_type TRANS_IDLE   = 2'h0;
  localparam cxb_trans_type TRANS_NONSEQ = 2'h2;

  localparam cxb_slave_type SLV_SHARED = 2'h0;
  localparam cxb_slave_type SLV_SRAM   = 2'h1;
  localparam cxb_slave_type SLV_NONE   = 2'h2;

  // ==========================================================================
  // Address map, top nibble of the address
  // ==========================================================================
  localparam int            REGION_LSB    = 28;
  localparam logic [3:0]    REGION_FLASH  = 4'h0;
  localparam logic [3:0]    REGION_EXT0   = 4'h2;
  localparam logic [3:0]    REGION_EXT1   = 4'h3;
  localparam logic [3:0]    REGION_SRAM   = 4'h4;
  localparam logic [3:0]    REGION_BRIDGE = 4'hF;

  // ==========================================================================
  // Ports, IDs, parking and priority
  // ==========================================================================
  localparam cxb_port_type PORT_CORE1_I = 3'h0;
  localparam cxb_port_type PORT_DMA     = 3'h1;
  localparam cxb_port_type PORT_COMM    = 3'h2;
  localparam cxb_port_type PORT_EXTBUS  = 3'h3;
  localparam cxb_port_type PORT_CORE1_D = 3'h4;
  localparam cxb_port_type PORT_CORE0   = 3'h5;

  localparam cxb_port_type PARK_SHARED     = PORT_CORE0;
  localparam cxb_port_type PARK_SRAM_RESET = PORT_CORE0;
  localparam cxb_port_type LAST_RESET      = 3'h5;

  localparam cxb_id_type ID_CORE1     = 4'h0;
  localparam cxb_id_type ID_CORE0     = 4'h1;
  localparam cxb_id_type ID_DMA       = 4'h2;
  localparam cxb_id_type ID_COMM      = 4'h3;
  localparam cxb_id_type ID_EXTBUS    = 4'h4;
  localparam cxb_id_type ID_DBG_CORE1 = 4'h8;
  localparam cxb_id_type ID_DBG_CORE0 = 4'h9;

  localparam cxb_port_type FIXED_ORDER [NUM_M] = '{
    PORT_DMA, PORT_COMM, PORT_EXTBUS, PORT_CORE0, PORT_CORE1_D, PORT_CORE1_I
  };

  // ==========================================================================
  // Decode functions
  // ==========================================================================
  function automatic cxb_slave_type cxb_decode(input logic [AW-1:0] addr);
    case (addr[AW-1:REGION_LSB])
      REGION_SRAM:   cxb_decode = SLV_SRAM;
      REGION_FLASH,
      REGION_EXT0,
      REGION_EXT1,
      REGION_BRIDGE: cxb_decode = SLV_SHARED;
      default:       cxb_decode = SLV_NONE;
    endcase
  endfunction : cxb_decode

  function automatic cxb_id_type cxb_master_id(input cxb_port_type port, input logic dbg);
    case (port)
      PORT_CORE1_I,
      PORT_CORE1_D: cxb_master_id = dbg ? ID_DBG_CORE1 : ID_CORE1;
      PORT_CORE0:   cxb_master_id = dbg ? ID_DBG_CORE0 : ID_CORE0;
      PORT_DMA:     cxb_master_id = ID_DMA;
      PORT_COMM:    cxb_master_id = ID_COMM;
      PORT_EXTBUS:  cxb_master_id = ID_EXTBUS;
      default:      cxb_master_id = ID_CORE1;
    endcase
  endfunction : cxb_master_id

endpackage : cxb_pkg

// >>> cxb_arb_if.sv
// Request and grant bundle between the crossbar top and one slave-port arbiter
`timescale 1ns/1ns
`default_nettype none
interface cxb_arb_if;
  import cxb_pkg::*;
  logic [NUM_M-1:0] req;
  cxb_port_type     last;
  logic             fixed_mode;
  logic             gnt_valid;
  cxb_port_type     gnt;

  modport arb  (input req, input last, input fixed_mode, output gnt_valid, output gnt);
  modport user (output req, output last, output fixed_mode, input gnt_valid, input gnt);
endinterface : cxb_arb_if
`default_nettype wire

// >>> cxb_arbiter.sv
// Round-robin or fixed-priority winner selection for one slave port
`timescale 1ns/1ns
`default_nettype none
module cxb_arbiter (
  cxb_arb_if.arb bus
);
  import cxb_pkg::*;

  // ==========================================================================
  // Winner selection
  // ==========================================================================
  always_comb begin
    int   idx;
    logic found;
    idx           = 0;
    found         = 1'b0;
    bus.gnt_valid = 1'b0;
    bus.gnt       = '0;
    if (bus.fixed_mode) begin
      for (int k = 0; k < NUM_M; k++) begin
        if (!found && bus.req[FIXED_ORDER[k]]) begin
          found   = 1'b1;
          bus.gnt = FIXED_ORDER[k];
        end
      end
    end else begin
      for (int k = 1; k <= NUM_M; k++) begin
        idx = (int'(bus.last) + k) % NUM_M;
        if (!found && bus.req[idx]) begin
          found   = 1'b1;
          bus.gnt = cxb_port_type'(idx);
        end
      end
    end
    bus.gnt_valid = found;
  end

endmodule : cxb_arbiter
`default_nettype wire

// >>> cxb_switch.sv
// Six-master, two-slave crossbar switch top level
`timescale 1ns/1ns
`default_nettype none
module cxb_switch (
  input  wire  logic                    mclk,
  input  wire  logic                    arst_n,
  input  wire  logic                    arbitration_priority_select,
  input  wire  logic [cxb_pkg::NUM_M-1:0] m_req,
  input  wire  cxb_pkg::cxb_maddr_type  m_addr,
  input  wire  logic [cxb_pkg::NUM_M-1:0] m_write,
  input  wire  cxb_pkg::cxb_msize_type  m_size,
  input  wire  cxb_pkg::cxb_mdata_type  m_wdata,
  input  wire  logic [cxb_pkg::NUM_M-1:0] m_dbg,
  output var   logic [cxb_pkg::NUM_M-1:0] m_done,
  output var   logic [cxb_pkg::NUM_M-1:0] m_err,
  output var   cxb_pkg::cxb_mdata_type  m_rdata,
  output var   cxb_pkg::cxb_strans_type s_trans,
  output var   cxb_pkg::cxb_saddr_type  s_addr,
  output var   logic [cxb_pkg::NUM_S-1:0] s_write,
  output var   cxb_pkg::cxb_ssize_type  s_size,
  output var   cxb_pkg::cxb_sdata_type  s_wdata,
  output var   cxb_pkg::cxb_sid_type    s_master_id,
  input  wire  logic [cxb_pkg::NUM_S-1:0] s_ready,
  input  wire  logic [cxb_pkg::NUM_S-1:0] s_err,
  input  wire  cxb_pkg::cxb_sdata_type  s_rdata
);
  import cxb_pkg::*;

  typedef enum logic [1:0] {
    CXB_ST_PARKED  = 2'b00,
    CXB_ST_HANDOFF = 2'b01,
    CXB_ST_ACTIVE  = 2'b10
  } cxb_state_type;

  // ==========================================================================
  // State
  // ==========================================================================
  cxb_state_type              state_reg [NUM_S];
  cxb_state_type              state_next [NUM_S];
  cxb_port_type               owner_reg [NUM_S];
  cxb_port_type               owner_next [NUM_S];
  cxb_port_type               last_reg [NUM_S];
  cxb_port_type               last_next [NUM_S];
  cxb_strans_type             s_trans_reg, s_trans_next;
  cxb_saddr_type              s_addr_reg, s_addr_next;
  logic [NUM_S-1:0]           s_write_reg, s_write_next;
  cxb_ssize_type              s_size_reg, s_size_next;
  cxb_sdata_type              s_wdata_reg, s_wdata_next;
  cxb_sid_type                s_id_reg, s_id_next;
  logic [NUM_M-1:0]           m_done_reg, m_done_next;
  logic [NUM_M-1:0]           m_err_reg, m_err_next;
  cxb_mdata_type              m_rdata_reg, m_rdata_next;
  logic [NUM_S-1:0][NUM_M-1:0] req_vec;
  logic [NUM_S-1:0]           gnt_valid;
  cxb_port_type               gnt [NUM_S];

  // ==========================================================================
  // Request decode
  // ==========================================================================
  always_comb begin
    req_vec = '0;
    for (int i = 0; i < NUM_M; i++) begin
      if (m_req[i] && !m_done_reg[i]) begin
        case (cxb_decode(m_addr[i]))
          SLV_SHARED: req_vec[0][i] = 1'b1;
          SLV_SRAM:   req_vec[1][i] = 1'b1;
          default:    req_vec[0][i] = 1'b0;
        endcase
      end
    end
  end

  // ==========================================================================
  // Per-slave arbiters
  // ==========================================================================
  cxb_arb_if arb_bus [NUM_S] ();

  generate
    for (genvar g = 0; g < NUM_S; g++) begin : g_arb
      assign arb_bus[g].req        = req_vec[g];
      assign arb_bus[g].last       = last_reg[g];
      assign arb_bus[g].fixed_mode = ~arbitration_priority_select;
      assign gnt_valid[g]          = arb_bus[g].gnt_valid;
      assign gnt[g]                = arb_bus[g].gnt;
      cxb_arbiter u_arb (
        .bus (arb_bus[g].arb)
      );
    end
  endgenerate

  // ==========================================================================
  // Slave port sequencing and master answers
  // ==========================================================================
  always_comb begin
    logic         launch;
    cxb_port_type lp;
    launch       = 1'b0;
    lp           = '0;
    state_next   = state_reg;
    owner_next   = owner_reg;
    last_next    = last_reg;
    s_trans_next = s_trans_reg;
    s_addr_next  = s_addr_reg;
    s_write_next = s_write_reg;
    s_size_next  = s_size_reg;
    s_wdata_next = s_wdata_reg;
    s_id_next    = s_id_reg;
    m_done_next  = '0;
    m_err_next   = '0;
    m_rdata_next = m_rdata_reg;
    for (int i = 0; i < NUM_M; i++) begin
      if (m_req[i] && !m_done_reg[i] && cxb_decode(m_addr[i]) == SLV_NONE) begin
        m_done_next[i]  = 1'b1;
        m_err_next[i]   = 1'b1;
        m_rdata_next[i] = '0;
      end
    end
    for (int s = 0; s < NUM_S; s++) begin
      launch = 1'b0;
      lp     = owner_reg[s];
      case (state_reg[s])
        CXB_ST_ACTIVE: begin
          if (s_ready[s]) begin
            state_next[s]              = CXB_ST_PARKED;
            s_trans_next[s]            = TRANS_IDLE;
            m_done_next[owner_reg[s]]  = 1'b1;
            m_err_next[owner_reg[s]]   = s_err[s];
            m_rdata_next[owner_reg[s]] = s_rdata[s];
            last_next[s]               = owner_reg[s];
          end
        end
        CXB_ST_HANDOFF: begin
          if (req_vec[s][owner_reg[s]]) begin
            launch = 1'b1;
          end else begin
            state_next[s] = CXB_ST_PARKED;
          end
        end
        CXB_ST_PARKED: begin
          if (gnt_valid[s]) begin
            if (gnt[s] == owner_reg[s]) begin
              launch = 1'b1;
            end else begin
              owner_next[s] = gnt[s];
              state_next[s] = CXB_ST_HANDOFF;
            end
          end else if (s == 0) begin
            owner_next[s] = PARK_SHARED;
          end
        end
        default: begin
          state_next[s]   = CXB_ST_PARKED;
          s_trans_next[s] = TRANS_IDLE;
        end
      endcase
      if (launch) begin
        state_next[s]   = CXB_ST_ACTIVE;
        s_trans_next[s] = TRANS_NONSEQ;
        s_addr_next[s]  = m_addr[lp];
        s_write_next[s] = m_write[lp];
        s_size_next[s]  = m_size[lp];
        s_wdata_next[s] = m_wdata[lp];
      end
      s_id_next[s] = cxb_master_id(owner_next[s], m_dbg[owner_next[s]]);
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg   <= '{default: CXB_ST_PARKED};
      owner_reg   <= '{PARK_SHARED, PARK_SRAM_RESET};
      last_reg    <= '{default: LAST_RESET};
      s_trans_reg <= '0;
      s_addr_reg  <= '0;
      s_write_reg <= '0;
      s_size_reg  <= '0;
      s_wdata_reg <= '0;
      s_id_reg    <= '{ID_CORE0, ID_CORE0};
      m_done_reg  <= '0;
      m_err_reg   <= '0;
      m_rdata_reg <= '0;
    end else begin
      state_reg   <= state_next;
      owner_reg   <= owner_next;
      last_reg    <= last_next;
      s_trans_reg <= s_trans_next;
      s_addr_reg  <= s_addr_next;
      s_write_reg <= s_write_next;
      s_size_reg  <= s_size_next;
      s_wdata_reg <= s_wdata_next;
      s_id_reg    <= s_id_next;
      m_done_reg  <= m_done_next;
      m_err_reg   <= m_err_next;
      m_rdata_reg <= m_rdata_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign m_done      = m_done_reg;
  assign m_err       = m_err_reg;
  assign m_rdata     = m_rdata_reg;
  assign s_trans     = s_trans_reg;
  assign s_addr      = s_addr_reg;
  assign s_write     = s_write_reg;
  assign s_size      = s_size_reg;
  assign s_wdata     = s_wdata_reg;
  assign s_master_id = s_id_reg;

endmodule : cxb_switch
`default_nettype wire

// >>> cxb_switch_monitor.sv
// Port-level assertion checker for the crossbar switch
`timescale 1ns/1ns
`default_nettype none
module cxb_switch_monitor (
  input wire logic                        mclk,
  input wire logic                        arst_n,
  input wire logic [cxb_pkg::NUM_M-1:0]   m_req,
  input wire cxb_pkg::cxb_maddr_type      m_addr,
  input wire logic [cxb_pkg::NUM_M-1:0]   m_done,
  input wire logic [cxb_pkg::NUM_M-1:0]   m_err,
  input wire cxb_pkg::cxb_strans_type     s_trans,
  input wire cxb_pkg::cxb_saddr_type      s_addr,
  input wire cxb_pkg::cxb_sid_type        s_master_id,
  input wire logic [cxb_pkg::NUM_S-1:0]   s_ready,
  input wire logic [cxb_pkg::NUM_S-1:0]   s_err
);
  import cxb_pkg::*;
  // ==========================================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_done_once; m_done != '0 |=> (m_done & $past(m_done)) == '0; endproperty
  a_done_once: assert property (p_done_once) else $error("done longer than one cycle");
  property p_unmapped; m_req[1] && !m_done[1]
    && !(m_addr[1][31:28] inside {4'h0, 4'h2, 4'h3, 4'h4, 4'hF}) |=> m_done[1] && m_err[1];
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_hold; s_trans[1] == TRANS_NONSEQ && !s_ready[1]
    |=> s_trans[1] == TRANS_NONSEQ && $stable(s_addr[1]); endproperty
  a_hold: assert property (p_hold) else $error("slave request dropped early");
  property p_idle_gap; s_trans[0] == TRANS_NONSEQ && s_ready[0] |=> s_trans[0] == TRANS_IDLE;
  endproperty
  a_idle_gap: assert property (p_idle_gap) else $error("shared port not idled");
  property p_sram_done; s_trans[1] == TRANS_NONSEQ && s_ready[1] && !s_err[1]
    && s_master_id[1] == ID_DMA |=> m_done[1] && !m_err[1]; endproperty
  a_sram_done: assert property (p_sram_done) else $error("sram completion lost");
  property p_err_pass; s_trans[0] == TRANS_NONSEQ && s_ready[0] && s_err[0]
    && s_master_id[0] == ID_DMA |=> m_done[1] && m_err[1]; endproperty
  a_err_pass: assert property (p_err_pass) else $error("slave error not passed");
  property p_owner_req; s_trans[1] == TRANS_NONSEQ && s_master_id[1] == ID_DMA |-> m_req[1];
  endproperty
  a_owner_req: assert property (p_owner_req) else $error("transfer without request");
  property p_reset_park; $rose(arst_n) |-> s_master_id == {ID_CORE0, ID_CORE0} && s_trans == '0;
  endproperty
  a_reset_park: assert property (p_reset_park) else $error("bad park after reset");
  property p_handoff; $rose(m_req[1]) && m_addr[1][31:28] == 4'h4 && s_master_id[1] != ID_DMA
    |=> !(s_trans[1] == TRANS_NONSEQ && s_master_id[1] == ID_DMA); endproperty
  a_handoff: assert property (p_handoff) else $error("handoff without delay");
  property p_park_shared; m_req == '0 [*4] |-> s_master_id[0] == ID_CORE0
    && s_trans[0] == TRANS_IDLE; endproperty
  a_park_shared: assert property (p_park_shared) else $error("shared port not parked");
endmodule : cxb_switch_monitor
bind cxb_switch cxb_switch_monitor cxb_switch_monitor_i (.mclk, .arst_n, .m_req, .m_addr,
  .m_done, .m_err, .s_trans, .s_addr, .s_master_id, .s_ready, .s_err);
`default_nettype wire

// >>> cxb_slave_model.sv
// Behavioural model of the two memory slaves
`timescale 1ns/1ns
`default_nettype none
module cxb_slave_model (
  input  wire logic                      mclk,
  input  wire logic                      arst_n,
  input  wire logic [2:0]                wait_cyc,
  input  wire cxb_pkg::cxb_strans_type   s_trans,
  input  wire cxb_pkg::cxb_saddr_type    s_addr,
  output var  logic [1:0]                s_ready,
  output var  logic [1:0]                s_err,
  output var  cxb_pkg::cxb_sdata_type    s_rdata
);
  import cxb_pkg::*;
  // ==========================================================================
  // Wait counting, answer and idle noise
  logic [2:0]  cnt [2];
  logic [31:0] noise;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      noise <= 32'h0;
      cnt   <= '{default: 3'h0};
    end else begin
      noise <= noise + 32'h9E3779B9;
      for (int s = 0; s < 2; s++) begin
        cnt[s] <= (s_ready[s] || s_trans[s] != TRANS_NONSEQ) ? 3'h0 : cnt[s] + 3'h1;
      end
    end
  end
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      s_ready[s] = s_trans[s] == TRANS_NONSEQ && cnt[s] >= wait_cyc;
      s_err[s]   = s_ready[s] && s_addr[s][7:0] == 8'hEE;
      s_rdata[s] = s_ready[s] ? ~s_addr[s] : noise;
    end
  end
endmodule : cxb_slave_model
`default_nettype wire

// >>> test_crossbar_switch_six_by_two.sv
// Self-checking bench for the six-by-two crossbar switch
`timescale 1ns/1ns
`default_nettype none
module test_crossbar_switch_six_by_two;
  import cxb_pkg::*;
  // ==========================================================================
  // Signals and instances
  logic                 mclk, arst_n, sel;
  logic [NUM_M-1:0]     m_req, m_write, m_dbg, m_done, m_err;
  cxb_maddr_type        m_addr;
  cxb_msize_type        m_size;
  cxb_mdata_type        m_wdata, m_rdata;
  cxb_strans_type       s_trans;
  cxb_saddr_type        s_addr;
  cxb_sdata_type        s_wdata, s_rdata;
  cxb_ssize_type        s_size;
  cxb_sid_type          s_master_id;
  logic [NUM_S-1:0]     s_write, s_ready, s_err;
  logic [2:0]           wait_cyc;
  int                   fail_count, checks;
  cxb_port_type         order[$];
  cxb_id_type           id_seen[NUM_M];
  logic [31:0]          addr_seen[NUM_M];
  time                  done_t[NUM_M];
  cxb_switch cxb_switch_i (.mclk, .arst_n, .arbitration_priority_select(sel), .m_req, .m_addr,
    .m_write, .m_size, .m_wdata, .m_dbg, .m_done, .m_err, .m_rdata, .s_trans, .s_addr,
    .s_write, .s_size, .s_wdata, .s_master_id, .s_ready, .s_err, .s_rdata);
  cxb_slave_model cxb_slave_model_i (.mclk, .arst_n, .wait_cyc, .s_trans, .s_addr, .s_ready,
    .s_err, .s_rdata);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ==========================================================================
  // Shared tasks
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic xfer(int q, logic [31:0] a, logic w, logic d);
    logic unm;
    logic s;
    unm = !(a[31:28] inside {4'h0, 4'h2, 4'h3, 4'h4, 4'hF});
    s = a[31:28] == 4'h4;
    id_seen[q] = 4'hX;
    addr_seen[q] = 32'hX;
    @(negedge mclk);
    m_addr[q] = a;
    m_write[q] = w;
    m_dbg[q] = d;
    m_wdata[q] = ~a;
    m_req[q] = 1'b1;
    for (int k = 0; k < 300; k++) begin
      @(negedge mclk);
      if (s_trans[s] == TRANS_NONSEQ && s_addr[s] === a) begin
        id_seen[q] = s_master_id[s];
        addr_seen[q] = s_addr[s];
        chk("write", s_write[s], w);
        chk("wdata", s_wdata[s], ~a);
        chk("size", s_size[s], 32'h2);
      end
      if (m_done[q]) begin
        m_req[q] = 1'b0;
        m_dbg[q] = 1'b0;
        order.push_back(q[2:0]);
        done_t[q] = $time;
        chk("err", m_err[q], unm || a[7:0] == 8'hEE);
        if (!w) chk("rdata", m_rdata[q], unm ? 32'h0 : ~a);
        return;
      end
    end
    fail_count++;
    end_of_test();
  endtask : xfer
  task automatic multi(logic md, logic [5:0] mask, logic [19:0] e);
    sel = md;
    order.delete();
    for (int q = 0; q < NUM_M; q++)
      if (mask[q])
        fork
          automatic int p = q;
          xfer(p, {4'h4, 16'h0, 4'(p), 8'h00}, 1'b0, 1'b0);
        join_none
    wait fork;
    for (int k = 0; k < 5; k++) chk("order", order[k], e[19-4*k -: 4]);
  endtask : multi
  // ==========================================================================
  // Scenarios
  task automatic t_conc();
    wait_cyc = 3'h2;
    fork
      xfer(1, 32'h4000_0100, 1'b0, 1'b0);
      xfer(2, 32'h0000_0200, 1'b0, 1'b0);
    join
    chk("conc", done_t[1] == done_t[2], 1'b1);
  endtask : t_conc
  task automatic t_ids();
    cxb_id_type idt[2][NUM_M] = '{'{4'h0, 4'h2, 4'h3, 4'h4, 4'h0, 4'h1},
                                  '{4'h8, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9}};
    wait_cyc = 3'h0;
    for (int d = 0; d < 2; d++)
      for (int q = 0; q < NUM_M; q++) begin
        xfer(q, {4'h4, 20'h0, 4'(q), 4'(d)}, 1'b0, d[0]);
        chk("id", id_seen[q], idt[d][q]);
        chk("addr", addr_seen[q], {4'h4, 20'h0, 4'(q), 4'(d)});
      end
  endtask : t_ids
  task automatic t_map();
    logic [31:0] al[8] = '{32'h0000_0010, 32'h2000_0020, 32'h3000_0030, 32'hF000_0040,
                           32'h0000_00EE, 32'h4000_00EE, 32'h1000_0050, 32'h8000_0060};
    wait_cyc = 3'h1;
    foreach (al[k]) begin
      xfer(1, al[k], k[0], 1'b0);
      if (k < 6) chk("route", addr_seen[1], al[k]);
    end
  endtask : t_map
  task automatic t_shared();
    wait_cyc = 3'h3;
    fork
      xfer(5, 32'h0000_0500, 1'b0, 1'b0);
      xfer(4, 32'hF000_0400, 1'b0, 1'b0);
    join
    chk("block", done_t[5] >= done_t[4] + 40, 1'b1);
  endtask : t_shared
  task automatic t_reset();
    xfer(2, 32'h0000_0700, 1'b0, 1'b0);
    repeat (6) @(negedge mclk);
    chk("park0", s_master_id[0], ID_CORE0);
    chk("park1", s_master_id[1], ID_DMA);
    chk("idle0", s_trans, 4'h0);
    arst_n = 1'b0;
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    chk("repark", s_master_id, {ID_CORE0, ID_CORE0});
    chk("reidle", s_trans, 4'h0);
    multi(1'b1, 6'h3F, 20'h01234);
  endtask : t_reset
  // ==========================================================================
  // Main sequence
  initial begin
    m_req = '0;
    m_write = '0;
    m_dbg = '0;
    m_addr = '0;
    m_wdata = '0;
    m_size = {NUM_M{3'h2}};
    sel = 1'b1;
    wait_cyc = 3'h0;
    arst_n = 1'b0;
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    chk("park", s_master_id, {ID_CORE0, ID_CORE0});
    chk("idle", s_trans, 4'h0);
    t_conc();
    t_ids();
    t_map();
    multi(1'b0, 6'h3D, 20'h23540);
    xfer(2, 32'h4000_0900, 1'b0, 1'b0);
    multi(1'b1, 6'h3B, 20'h34501);
    t_shared();
    t_reset();
    end_of_test();
  end
endmodule : test_crossbar_switch_six_by_two
`default_nettype wire
